// File: pkg/dod_pkg.sv
// Opcode patterns, selector and test pair codes, word and cycle counts for the decoder slice
package dod_pkg;

  // ==========================================================================
  // Opcode patterns
  localparam logic [5:0] COND_BRANCH_HI = 6'h38;
  localparam logic [5:0] COND_CALL_HI = 6'h3A;
  localparam logic [7:0] FLAG_TEST_TEMP_HI = 8'h6F;
  localparam logic [7:0] BLK_DD_SRC_HI = 8'hA8;
  localparam logic [7:0] BLK_DD_DST_HI = 8'hA9;
  localparam logic [7:0] BLK_PD_HI = 8'hA5;
  localparam logic [11:0] FLAG_CLEAR_HI = 12'hBE4;
  localparam logic [13:0] AUX_CMP_HI = 14'h2FD1;
  localparam logic [7:0] DATA_SHIFT_COPY_HI = 8'h77;
  localparam logic [7:0] PORT_READ_HI = 8'hAF;
  localparam logic [3:0] ACC_LOAD_SHIFTED_HI = 4'h1;
  localparam logic [11:0] ACC_LOAD_LONG_HI = 12'hBF8;
  localparam logic [7:0] ACC_ZERO_LOAD_HIGH_HI = 8'h6A;
  localparam logic [7:0] ACC_LOAD_LOW_IMM_HI = 8'hB9;
  localparam logic [7:0] ACC_LOAD_LOW_UNS_HI = 8'h69;
  localparam logic [7:0] ACC_LOAD_TEMP_SHIFT_HI = 8'h6B;
  localparam logic [4:0] AUX_LOAD_SHORT_HI = 5'h16;
  localparam logic [12:0] AUX_LOAD_LONG_HI = 13'h17E1;
  localparam logic [6:0] PAGE_PTR_IMM_HI = 7'h5E;
  localparam logic [7:0] PAGE_PTR_MEM_HI = 8'h0D;
  localparam logic [7:0] STATUS_ZERO_HI = 8'h0E;
  localparam logic [7:0] STATUS_ONE_HI = 8'h0F;
  localparam logic [3:0] TEMP_GROUP_HI = 4'h7;
  localparam logic [3:0] TEMP_SUB_LOAD = 4'h3;
  localparam logic [3:0] TEMP_SUB_ADD = 4'h0;
  localparam logic [3:0] TEMP_SUB_COPY = 4'h1;
  localparam logic [3:0] TEMP_SUB_MOVE = 4'h2;
  localparam logic [3:0] TEMP_SUB_PRODUCT_HIGH = 4'h5;

  // ==========================================================================
  // Flag clear group selectors
  localparam logic [3:0] CLR_BLOCK_DATA = 4'h4;
  localparam logic [3:0] CLR_IRQ_ENABLE = 4'h0;
  localparam logic [3:0] CLR_CARRY = 4'hE;
  localparam logic [3:0] CLR_OVF_MODE = 4'h2;
  localparam logic [3:0] CLR_SIGN_EXT = 4'h6;
  localparam logic [3:0] CLR_TEST_CTRL = 4'hA;
  localparam logic [3:0] CLR_EXT_OUT = 4'hC;

  // ==========================================================================
  // Test pair codes
  localparam logic [1:0] TP_PIN_LOW = 2'h0;
  localparam logic [1:0] TP_FLAG_SET = 2'h1;
  localparam logic [1:0] TP_FLAG_CLEAR = 2'h2;
  localparam logic [1:0] TP_NONE = 2'h3;

  // ==========================================================================
  // Word and cycle counts
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  typedef enum logic [4:0] {
    OP_NONE, OP_COND_BRANCH, OP_COND_CALL, OP_FLAG_TEST_TEMP, OP_BLK_DD_SRC,
    OP_BLK_DD_DST, OP_BLK_PD, OP_FLAG_CLEAR, OP_AUX_CMP, OP_DATA_SHIFT_COPY,
    OP_PORT_READ, OP_ACC_LOAD_SHIFTED, OP_ACC_LOAD_LONG, OP_ACC_ZERO_LOAD_HIGH,
    OP_ACC_LOAD_LOW_IMM, OP_ACC_LOAD_LOW_UNS, OP_ACC_LOAD_TEMP_SHIFT,
    OP_AUX_LOAD_SHORT, OP_AUX_LOAD_LONG, OP_PAGE_PTR_IMM, OP_PAGE_PTR_MEM,
    OP_STATUS_LOAD_ZERO, OP_STATUS_LOAD_ONE, OP_TEMP_LOAD, OP_TEMP_LOAD_ADD,
    OP_TEMP_LOAD_COPY, OP_TEMP_LOAD_MOVE, OP_PRODUCT_HIGH_LOAD
  } dod_op_e;

  typedef enum logic {
    ST_FIRST, ST_SECOND
  } dod_state_e;

endpackage

// File: design/dod_cond_eval.sv
// Condition evaluator for the conditional branch and call encodings
`timescale 1ns/100ps
`default_nettype none
module dod_cond_eval (
  input wire logic [3:0] mask,
  input wire logic [3:0] cond_flag_nibble,
  input wire logic [3:0] live_flags,
  input wire logic [1:0] test_pair_field,
  input wire logic pin_low,
  input wire logic test_ctrl_flag,
  output logic cond_met
);
  logic cond_flag_nibble_hit;
  logic pair_hit;

  // Mask picks the flags, any picked flag matching its state passes
  assign cond_flag_nibble_hit = |(mask & ~(cond_flag_nibble ^ live_flags));

  always_comb begin
    unique case (test_pair_field)
      dod_pkg::TP_PIN_LOW: pair_hit = pin_low;
      dod_pkg::TP_FLAG_SET: pair_hit = test_ctrl_flag;
      dod_pkg::TP_FLAG_CLEAR: pair_hit = ~test_ctrl_flag;
      dod_pkg::TP_NONE: pair_hit = 1'b0;
    endcase
  end

  assign cond_met = cond_flag_nibble_hit | pair_hit;
endmodule
`default_nettype wire

// File: design/dod_decoder.sv
// Instruction decoder slice: branch-on-condition through temp register loads
// Notes on behaviour
// - Conditional branch with accumulator zero test: two words, 4 taken, 2 not, 3 not with test pair 00.
// - Flag test by temp register: upper byte 6F, one word, one cycle.
// - Data-to-data copy, immediate source: upper byte A8, two words.
// - Data-to-data copy, immediate destination: upper byte A9, second word.
// - Program-to-data copy: upper byte A5, program address in second word.
// - Flag clear group BE4x, low nibble picks the flag cleared.
// - Aux compare BF44..BF47, selector in low two bits, one cycle.
// - Data shift copy: upper byte 77, one word, one cycle.
// - Port read: upper byte AF, port address second word, 2/2.
// - Shifted accumulator load: top nibble 1, shift in bits 11..8.
// - Long immediate accumulator load BF8x, constant word follows, 2/2.
// - Zero low, load high accumulator: upper byte 6A, one cycle.
// - Short immediate low load B9; zero constant means accumulator clear.
// - Zero low, load low unsigned: upper byte 69, one cycle.
// - Accumulator load with temp register shift: upper byte 6B.
// - Aux short load 1011 0xxx with eight-bit constant, 1/2.
// - Aux long load BF08..BF0F with constant word, 2/2.
// - Page pointer immediate 1011110 plus nine bits; memory form 0D, 2 cycles.
// - Status word loads 0E and 0F, two cycles each.
// - Temp group top nibble 7: 3 load, 0 add, 1 copy, 2 move, 5 product high.
// - Condition mask ANDed with live flags versus state; any match passes.
// - Test pair 00 pin low, 01 flag set, 10 flag clear, 11 none.
`timescale 1ns/100ps
`default_nettype none
module dod_decoder (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic acc_zero,
  input wire logic acc_negative,
  input wire logic overflow_flag,
  input wire logic carry_flag,
  input wire logic test_ctrl_flag,
  input wire logic ext_branch_input_pin,
  output logic dec_valid,
  output var dod_pkg::dod_op_e op_class,
  output logic [1:0] word_count,
  output logic [2:0] cycle_count,
  output logic [7:0] operand_addr,
  output logic [3:0] shift_count_field,
  output logic [2:0] aux_select_field,
  output logic [1:0] compare_selector,
  output logic [3:0] clear_select,
  output logic [15:0] imm_value,
  output logic cond_met,
  output logic acc_clear,
  output logic op_unknown
);

  // ==========================================================================
  // Helpers
  function automatic logic is_two_word(input dod_pkg::dod_op_e op);
    unique case (op)
      dod_pkg::OP_COND_BRANCH, dod_pkg::OP_COND_CALL, dod_pkg::OP_BLK_DD_SRC,
      dod_pkg::OP_BLK_DD_DST, dod_pkg::OP_BLK_PD, dod_pkg::OP_PORT_READ,
      dod_pkg::OP_ACC_LOAD_LONG, dod_pkg::OP_AUX_LOAD_LONG: is_two_word = 1'b1;
      default: is_two_word = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] base_cycles(input dod_pkg::dod_op_e op);
    unique case (op)
      dod_pkg::OP_BLK_DD_SRC, dod_pkg::OP_BLK_DD_DST,
      dod_pkg::OP_BLK_PD: base_cycles = dod_pkg::CYC_THREE;
      dod_pkg::OP_PORT_READ, dod_pkg::OP_ACC_LOAD_LONG, dod_pkg::OP_AUX_LOAD_LONG,
      dod_pkg::OP_AUX_LOAD_SHORT, dod_pkg::OP_PAGE_PTR_IMM, dod_pkg::OP_PAGE_PTR_MEM,
      dod_pkg::OP_STATUS_LOAD_ZERO,
      dod_pkg::OP_STATUS_LOAD_ONE: base_cycles = dod_pkg::CYC_TWO;
      default: base_cycles = dod_pkg::CYC_ONE;
    endcase
  endfunction

  // ==========================================================================
  // Pin synchroniser
  logic pin_meta_reg;
  logic pin_sync_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= ext_branch_input_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================================
  // First word decode
  dod_pkg::dod_op_e op_dec;
  logic [15:0] w;
  logic cond_eval;

  assign w = fetch_word;

  always_comb begin
    op_dec = dod_pkg::OP_NONE;
    if (w[15:10] == dod_pkg::COND_BRANCH_HI) begin
      op_dec = dod_pkg::OP_COND_BRANCH;
    end else if (w[15:10] == dod_pkg::COND_CALL_HI) begin
      op_dec = dod_pkg::OP_COND_CALL;
    end else if (w[15:8] == dod_pkg::FLAG_TEST_TEMP_HI) begin
      op_dec = dod_pkg::OP_FLAG_TEST_TEMP;
    end else if (w[15:8] == dod_pkg::BLK_DD_SRC_HI) begin
      op_dec = dod_pkg::OP_BLK_DD_SRC;
    end else if (w[15:8] == dod_pkg::BLK_DD_DST_HI) begin
      op_dec = dod_pkg::OP_BLK_DD_DST;
    end else if (w[15:8] == dod_pkg::BLK_PD_HI) begin
      op_dec = dod_pkg::OP_BLK_PD;
    end else if (w[15:4] == dod_pkg::FLAG_CLEAR_HI) begin
      unique case (w[3:0])
        dod_pkg::CLR_BLOCK_DATA, dod_pkg::CLR_IRQ_ENABLE, dod_pkg::CLR_CARRY,
        dod_pkg::CLR_OVF_MODE, dod_pkg::CLR_SIGN_EXT, dod_pkg::CLR_TEST_CTRL,
        dod_pkg::CLR_EXT_OUT: op_dec = dod_pkg::OP_FLAG_CLEAR;
        default: op_dec = dod_pkg::OP_NONE;
      endcase
    end else if (w[15:2] == dod_pkg::AUX_CMP_HI) begin
      op_dec = dod_pkg::OP_AUX_CMP;
    end else if (w[15:8] == dod_pkg::DATA_SHIFT_COPY_HI) begin
      op_dec = dod_pkg::OP_DATA_SHIFT_COPY;
    end else if (w[15:8] == dod_pkg::PORT_READ_HI) begin
      op_dec = dod_pkg::OP_PORT_READ;
    end else if (w[15:12] == dod_pkg::ACC_LOAD_SHIFTED_HI) begin
      op_dec = dod_pkg::OP_ACC_LOAD_SHIFTED;
    end else if (w[15:4] == dod_pkg::ACC_LOAD_LONG_HI) begin
      op_dec = dod_pkg::OP_ACC_LOAD_LONG;
    end else if (w[15:8] == dod_pkg::ACC_ZERO_LOAD_HIGH_HI) begin
      op_dec = dod_pkg::OP_ACC_ZERO_LOAD_HIGH;
    end else if (w[15:8] == dod_pkg::ACC_LOAD_LOW_IMM_HI) begin
      op_dec = dod_pkg::OP_ACC_LOAD_LOW_IMM;
    end else if (w[15:8] == dod_pkg::ACC_LOAD_LOW_UNS_HI) begin
      op_dec = dod_pkg::OP_ACC_LOAD_LOW_UNS;
    end else if (w[15:8] == dod_pkg::ACC_LOAD_TEMP_SHIFT_HI) begin
      op_dec = dod_pkg::OP_ACC_LOAD_TEMP_SHIFT;
    end else if (w[15:11] == dod_pkg::AUX_LOAD_SHORT_HI) begin
      op_dec = dod_pkg::OP_AUX_LOAD_SHORT;
    end else if (w[15:3] == dod_pkg::AUX_LOAD_LONG_HI) begin
      op_dec = dod_pkg::OP_AUX_LOAD_LONG;
    end else if (w[15:9] == dod_pkg::PAGE_PTR_IMM_HI) begin
      op_dec = dod_pkg::OP_PAGE_PTR_IMM;
    end else if (w[15:8] == dod_pkg::PAGE_PTR_MEM_HI) begin
      op_dec = dod_pkg::OP_PAGE_PTR_MEM;
    end else if (w[15:8] == dod_pkg::STATUS_ZERO_HI) begin
      op_dec = dod_pkg::OP_STATUS_LOAD_ZERO;
    end else if (w[15:8] == dod_pkg::STATUS_ONE_HI) begin
      op_dec = dod_pkg::OP_STATUS_LOAD_ONE;
    end else if (w[15:12] == dod_pkg::TEMP_GROUP_HI) begin
      unique case (w[11:8])
        dod_pkg::TEMP_SUB_LOAD: op_dec = dod_pkg::OP_TEMP_LOAD;
        dod_pkg::TEMP_SUB_ADD: op_dec = dod_pkg::OP_TEMP_LOAD_ADD;
        dod_pkg::TEMP_SUB_COPY: op_dec = dod_pkg::OP_TEMP_LOAD_COPY;
        dod_pkg::TEMP_SUB_MOVE: op_dec = dod_pkg::OP_TEMP_LOAD_MOVE;
        dod_pkg::TEMP_SUB_PRODUCT_HIGH: op_dec = dod_pkg::OP_PRODUCT_HIGH_LOAD;
        default: op_dec = dod_pkg::OP_NONE;
      endcase
    end
  end

  // Flags are sampled when the first word arrives
  dod_cond_eval u_cond (
    .mask(w[3:0]),
    .cond_flag_nibble(w[7:4]),
    .live_flags({acc_zero, acc_negative, overflow_flag, carry_flag}),
    .test_pair_field(w[9:8]),
    .pin_low(~pin_sync_reg),
    .test_ctrl_flag(test_ctrl_flag),
    .cond_met(cond_eval)
  );

  // ==========================================================================
  // Sequencing of one and two word forms
  dod_pkg::dod_state_e state_reg;
  dod_pkg::dod_state_e state_next;
  logic emit;

  always_comb begin
    state_next = state_reg;
    emit = 1'b0;
    unique case (state_reg)
      dod_pkg::ST_FIRST: begin
        if (fetch_valid && is_two_word(op_dec)) begin
          state_next = dod_pkg::ST_SECOND;
        end else if (fetch_valid) begin
          emit = 1'b1;
        end
      end
      dod_pkg::ST_SECOND: begin
        if (fetch_valid) begin
          emit = 1'b1;
          state_next = dod_pkg::ST_FIRST;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dod_pkg::ST_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  // First word held while the second is awaited
  dod_pkg::dod_op_e held_op_reg;
  logic [15:0] held_word_reg;
  logic held_cond_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      held_op_reg <= dod_pkg::OP_NONE;
      held_word_reg <= 16'h0000;
      held_cond_reg <= 1'b0;
    end else if (state_reg == dod_pkg::ST_FIRST && fetch_valid) begin
      held_op_reg <= op_dec;
      held_word_reg <= w;
      held_cond_reg <= cond_eval;
    end
  end

  // ==========================================================================
  // Output fields
  dod_pkg::dod_op_e op_sel;
  logic [15:0] fw;
  logic c_sel;
  logic [2:0] cyc_sel;
  logic [15:0] imm_sel;

  assign op_sel = (state_reg == dod_pkg::ST_SECOND) ? held_op_reg : op_dec;
  assign fw = (state_reg == dod_pkg::ST_SECOND) ? held_word_reg : w;
  assign c_sel = (state_reg == dod_pkg::ST_SECOND) ? held_cond_reg : cond_eval;

  always_comb begin
    cyc_sel = base_cycles(op_sel);
    imm_sel = {8'h00, fw[7:0]};
    if (op_sel == dod_pkg::OP_COND_BRANCH || op_sel == dod_pkg::OP_COND_CALL) begin
      if (c_sel) begin
        cyc_sel = dod_pkg::CYC_FOUR;
      end else if (fw[9:8] == dod_pkg::TP_PIN_LOW) begin
        cyc_sel = dod_pkg::CYC_THREE;
      end else begin
        cyc_sel = dod_pkg::CYC_TWO;
      end
    end
    if (is_two_word(op_sel)) begin
      imm_sel = w;
    end else if (op_sel == dod_pkg::OP_PAGE_PTR_IMM) begin
      imm_sel = {7'h00, fw[8:0]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= emit;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_class <= dod_pkg::OP_NONE;
      word_count <= 2'h0;
      cycle_count <= 3'h0;
      operand_addr <= 8'h00;
      shift_count_field <= 4'h0;
      aux_select_field <= 3'h0;
      compare_selector <= 2'h0;
      clear_select <= 4'h0;
      imm_value <= 16'h0000;
      cond_met <= 1'b0;
      acc_clear <= 1'b0;
      op_unknown <= 1'b0;
    end else if (emit) begin
      op_class <= op_sel;
      word_count <= is_two_word(op_sel) ? dod_pkg::WORDS_TWO : dod_pkg::WORDS_ONE;
      cycle_count <= cyc_sel;
      operand_addr <= fw[7:0];
      shift_count_field <= (op_sel == dod_pkg::OP_ACC_LOAD_LONG) ? fw[3:0] : fw[11:8];
      aux_select_field <= (op_sel == dod_pkg::OP_AUX_LOAD_SHORT) ? fw[10:8] : fw[2:0];
      compare_selector <= fw[1:0];
      clear_select <= fw[3:0];
      imm_value <= imm_sel;
      cond_met <= c_sel;
      acc_clear <= (op_sel == dod_pkg::OP_ACC_LOAD_LOW_IMM) && (fw[7:0] == 8'h00);
      op_unknown <= (op_sel == dod_pkg::OP_NONE);
    end
  end

  // ==========================================================================
  // Checks
  a_branch_taken_cycles: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dec_valid && op_class == dod_pkg::OP_COND_BRANCH |->
      cycle_count == (cond_met ? 3'h4 : (held_word_reg[9:8] == 2'h0 ? 3'h3 : 3'h2))
      && word_count == 2'h2)
    else $error("branch word or cycle count wrong");

  a_flag_test_one: assert property (
    @(posedge core_clk) disable iff (!resetn)
    state_reg == dod_pkg::ST_FIRST && fetch_valid && fetch_word[15:8] == 8'h6F |=>
      dec_valid && op_class == dod_pkg::OP_FLAG_TEST_TEMP && cycle_count == 3'h1)
    else $error("flag test by temp not decoded in one cycle");

  a_blk_waits_second: assert property (
    @(posedge core_clk) disable iff (!resetn)
    state_reg == dod_pkg::ST_FIRST && fetch_valid && fetch_word[15:8] == 8'hA8 |=>
      !dec_valid && state_reg == dod_pkg::ST_SECOND && held_op_reg == dod_pkg::OP_BLK_DD_SRC)
    else $error("block copy did not wait for its second word");

  a_blk_pairs_second: assert property (
    @(posedge core_clk) disable iff (!resetn)
    state_reg == dod_pkg::ST_SECOND && fetch_valid
      && held_op_reg == dod_pkg::OP_BLK_DD_SRC |=>
      dec_valid && op_class == dod_pkg::OP_BLK_DD_SRC && imm_value == $past(fetch_word))
    else $error("block copy second word not paired");

  a_clear_sel_legal: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dec_valid && op_class == dod_pkg::OP_FLAG_CLEAR |->
      clear_select inside {4'h4, 4'h0, 4'hE, 4'h2, 4'h6, 4'hA, 4'hC})
    else $error("flag clear selector outside group");

  a_shift_copy_addr: assert property (
    @(posedge core_clk) disable iff (!resetn)
    state_reg == dod_pkg::ST_FIRST && fetch_valid && fetch_word[15:8] == 8'h77 |=>
      op_class == dod_pkg::OP_DATA_SHIFT_COPY && operand_addr == $past(fetch_word[7:0]))
    else $error("data shift copy address lost");

  a_port_read_count: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dec_valid && op_class == dod_pkg::OP_PORT_READ |-> word_count == 2'h2 && cycle_count == 3'h2)
    else $error("port read counts wrong");

  a_acc_clear_zero: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dec_valid |-> acc_clear == (op_class == dod_pkg::OP_ACC_LOAD_LOW_IMM && imm_value == 16'h0000))
    else $error("accumulator clear flag mismatch");

  a_page_imm_field: assert property (
    @(posedge core_clk) disable iff (!resetn)
    state_reg == dod_pkg::ST_FIRST && fetch_valid && fetch_word[15:9] == 7'h5E |=>
      op_class == dod_pkg::OP_PAGE_PTR_IMM && imm_value[8:0] == $past(fetch_word[8:0])
      && cycle_count == 3'h2)
    else $error("page pointer immediate wrong");

  a_status_two_cyc: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dec_valid && op_class inside {dod_pkg::OP_STATUS_LOAD_ZERO, dod_pkg::OP_STATUS_LOAD_ONE}
      |-> cycle_count == 3'h2 && word_count == 2'h1)
    else $error("status load counts wrong");

endmodule
`default_nettype wire

// File: verif/dod_core_model.sv
// Core fetch model: hands instruction words to the decoder one strobe at a time
`timescale 1ns/100ps
`default_nettype none
module dod_core_model (
  input wire logic core_clk,
  output logic fetch_valid,
  output logic [15:0] fetch_word
);
  initial begin
    fetch_valid = 1'b0;
    fetch_word = 16'h0000;
  end

  task automatic send(input logic [15:0] w, input int gap);
    @(negedge core_clk);
    fetch_valid = 1'b1;
    fetch_word = w;
    @(negedge core_clk);
    fetch_valid = 1'b0;
    // Released bus shows the inverse so a stale word is never mistaken
    fetch_word = ~w;
    repeat (gap) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the decoder slice
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic fetch_valid;
  logic [15:0] fetch_word;
  logic acc_zero = 1'b0, acc_negative = 1'b0, overflow_flag = 1'b0, carry_flag = 1'b0;
  logic test_ctrl_flag = 1'b0, ext_branch_input_pin = 1'b1;
  logic dec_valid, cond_met, acc_clear, op_unknown;
  dod_pkg::dod_op_e op_class;
  logic [1:0] word_count, compare_selector;
  logic [2:0] cycle_count, aux_select_field;
  logic [7:0] operand_addr;
  logic [3:0] shift_count_field, clear_select;
  logic [15:0] imm_value;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #2 core_clk = ~core_clk;

  dod_core_model i_core (.core_clk(core_clk), .fetch_valid(fetch_valid), .fetch_word(fetch_word));

  dod_decoder i_dut (.core_clk(core_clk), .resetn(resetn), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .acc_zero(acc_zero), .acc_negative(acc_negative),
    .overflow_flag(overflow_flag), .carry_flag(carry_flag), .test_ctrl_flag(test_ctrl_flag),
    .ext_branch_input_pin(ext_branch_input_pin), .dec_valid(dec_valid), .op_class(op_class),
    .word_count(word_count), .cycle_count(cycle_count), .operand_addr(operand_addr),
    .shift_count_field(shift_count_field), .aux_select_field(aux_select_field),
    .compare_selector(compare_selector), .clear_select(clear_select), .imm_value(imm_value),
    .cond_met(cond_met), .acc_clear(acc_clear), .op_unknown(op_unknown));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Sends one instruction, waits for its decode pulse and checks the pulse is one cycle
  task automatic dec(input logic [15:0] w0, input logic [15:0] w1, input bit two);
    int n;
    i_core.send(w0, two ? 2 : 0);
    if (two)
      i_core.send(w1, 0);
    n = 0;
    while (dec_valid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    chk("dec_valid", 16'h1, 16'(dec_valid));
    @(negedge core_clk);
    chk("dec_valid_drop", 16'h0, 16'(dec_valid));
  endtask

  task automatic exp4(input dod_pkg::dod_op_e op, input logic [1:0] wc, input logic [2:0] cc,
    input logic [7:0] a);
    chk("op_class", 16'(op), 16'(op_class));
    chk("word_count", 16'(wc), 16'(word_count));
    chk("cycle_count", 16'(cc), 16'(cycle_count));
    chk("operand_addr", 16'(a), 16'(operand_addr));
  endtask

  task automatic t_one_word();
    logic [15:0] w[13] = '{16'h6F12, 16'h7705, 16'h6A33, 16'h6934, 16'h6B35, 16'h0E40,
      16'h0F41, 16'h0D42, 16'h7343, 16'h7044, 16'h7145, 16'h7246, 16'h7547};
    dod_pkg::dod_op_e op[13] = '{dod_pkg::OP_FLAG_TEST_TEMP, dod_pkg::OP_DATA_SHIFT_COPY,
      dod_pkg::OP_ACC_ZERO_LOAD_HIGH, dod_pkg::OP_ACC_LOAD_LOW_UNS,
      dod_pkg::OP_ACC_LOAD_TEMP_SHIFT, dod_pkg::OP_STATUS_LOAD_ZERO,
      dod_pkg::OP_STATUS_LOAD_ONE, dod_pkg::OP_PAGE_PTR_MEM, dod_pkg::OP_TEMP_LOAD,
      dod_pkg::OP_TEMP_LOAD_ADD, dod_pkg::OP_TEMP_LOAD_COPY, dod_pkg::OP_TEMP_LOAD_MOVE,
      dod_pkg::OP_PRODUCT_HIGH_LOAD};
    logic [2:0] cc;
    foreach (w[i]) begin
      cc = (i >= 5 && i <= 7) ? 3'h2 : 3'h1;
      dec(w[i], 16'h0000, 1'b0);
      exp4(op[i], 2'h1, cc, w[i][7:0]);
    end
    dec(16'h1A56, 16'h0000, 1'b0);
    exp4(dod_pkg::OP_ACC_LOAD_SHIFTED, 2'h1, 3'h1, 8'h56);
    chk("shift_count_field", 16'h000A, 16'(shift_count_field));
  endtask

  task automatic t_two_word();
    logic [15:0] w[6] = '{16'hA812, 16'hA913, 16'hA514, 16'hAF15, 16'hBF83, 16'hBF0D};
    logic [15:0] k[6] = '{16'h1111, 16'h0300, 16'hFFFF, 16'h2222, 16'h7FFF, 16'h8001};
    dod_pkg::dod_op_e op[6] = '{dod_pkg::OP_BLK_DD_SRC, dod_pkg::OP_BLK_DD_DST,
      dod_pkg::OP_BLK_PD, dod_pkg::OP_PORT_READ, dod_pkg::OP_ACC_LOAD_LONG,
      dod_pkg::OP_AUX_LOAD_LONG};
    foreach (w[i]) begin
      dec(w[i], k[i], 1'b1);
      exp4(op[i], 2'h2, (i < 3) ? 3'h3 : 3'h2, w[i][7:0]);
      chk("imm_value", k[i], imm_value);
      if (i == 4)
        chk("shift_count_field", 16'h0003, 16'(shift_count_field));
    end
    chk("aux_select_field", 16'h0005, 16'(aux_select_field));
  endtask

  task automatic t_flag_clear();
    logic [3:0] s[7] = '{4'h4, 4'h0, 4'hE, 4'h2, 4'h6, 4'hA, 4'hC};
    foreach (s[i]) begin
      dec({12'hBE4, s[i]}, 16'h0000, 1'b0);
      exp4(dod_pkg::OP_FLAG_CLEAR, 2'h1, 3'h1, {4'h4, s[i]});
      chk("clear_select", 16'(s[i]), 16'(clear_select));
    end
    dec(16'hBE45, 16'h0000, 1'b0);
    chk("op_unknown", 16'h1, 16'(op_unknown));
  endtask

  task automatic t_immediates();
    for (int k = 0; k < 4; k++) begin
      dec(16'hBF44 + 16'(k), 16'h0000, 1'b0);
      exp4(dod_pkg::OP_AUX_CMP, 2'h1, 3'h1, 8'h44 + 8'(k));
      chk("compare_selector", 16'(k), 16'(compare_selector));
    end
    dec(16'hB37D, 16'h0000, 1'b0);
    exp4(dod_pkg::OP_AUX_LOAD_SHORT, 2'h1, 3'h2, 8'h7D);
    chk("aux_select_field", 16'h0003, 16'(aux_select_field));
    dec(16'hB900, 16'h0000, 1'b0);
    chk("acc_clear", 16'h1, 16'(acc_clear));
    dec(16'hB95A, 16'h0000, 1'b0);
    exp4(dod_pkg::OP_ACC_LOAD_LOW_IMM, 2'h1, 3'h1, 8'h5A);
    chk("acc_clear", 16'h0, 16'(acc_clear));
    dec(16'hBD23, 16'h0000, 1'b0);
    exp4(dod_pkg::OP_PAGE_PTR_IMM, 2'h1, 3'h2, 8'h23);
    chk("imm_value", 16'h0123, imm_value);
  endtask

  // Flags are {zero, negative, overflow, carry, test flag, pin}
  task automatic t_cond();
    logic [15:0] w[8] = '{16'hE388, 16'hE388, 16'hE100, 16'hE200, 16'hE000, 16'hE000,
      16'hE800, 16'hEB44};
    logic [5:0] f[8] = '{6'h21, 6'h01, 6'h03, 6'h03, 6'h00, 6'h01, 6'h01, 6'h11};
    logic [2:0] cc[8] = '{3'h4, 3'h2, 3'h4, 3'h2, 3'h4, 3'h3, 3'h3, 3'h4};
    foreach (w[i]) begin
      {acc_zero, acc_negative, overflow_flag, carry_flag, test_ctrl_flag,
        ext_branch_input_pin} = f[i];
      repeat (3) @(negedge core_clk);
      dec(w[i], 16'hBEEF, 1'b1);
      exp4(i < 6 ? dod_pkg::OP_COND_BRANCH : dod_pkg::OP_COND_CALL, 2'h2, cc[i],
        w[i][7:0]);
      chk("cond_met", 16'(cc[i] == 3'h4), 16'(cond_met));
      chk("imm_value", 16'hBEEF, imm_value);
    end
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    t_one_word();
    t_two_word();
    t_flag_clear();
    t_immediates();
    t_cond();
    finish_test();
  end
endmodule
`default_nettype wire
